//--- snsr_pkg.sv
// shared constants, register map and types of the sensor input front end
package snsr_pkg;
	localparam int CLK_MHZ = 50;
	localparam int TICK_US = 250;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam real STAMP_MS = 0.5;
	localparam int STAMP_CYC = int'(STAMP_MS * 1000.0 * CLK_MHZ);
	localparam int US_CYC = CLK_MHZ;
	localparam int TRIG_US = 10;
	localparam int TRIG_CYC = TRIG_US * CLK_MHZ;
	localparam int NCH = 4;
	localparam int NPORT = 2;
	localparam int LINES = 4;
	localparam int ADC_W = 12;
	localparam int CNT_W = 16;
	localparam int MODE_W = 2;
	localparam int PM_W = 2;
	localparam int CM_RANGE_LSB = 8;
	localparam int IRQ_W = 6;
	localparam int PIN_ECHO = 0;
	localparam int PIN_TRIG = 1;
	localparam int PIN_CLK = 0;
	localparam int PIN_DIR = 1;
	localparam logic [ADC_W-1:0] THRESH_RST = 12'h800;
	localparam logic [7:0] REG_CHAN_MODE = 8'h00;
	localparam logic [7:0] REG_PORT_MODE = 8'h04;
	localparam logic [7:0] REG_DIO_DIR = 8'h08;
	localparam logic [7:0] REG_DIO_OUT = 8'h0c;
	localparam logic [7:0] REG_DIO_IN = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] REG_IRQ_MASK = 8'h18;
	localparam logic [7:0] REG_RANGE_GO = 8'h1c;
	localparam logic [7:0] REG_TIMESTAMP = 8'h20;
	localparam logic [7:0] REG_THRESH = 8'h40;
	localparam logic [7:0] REG_COUNT = 8'h50;
	localparam logic [7:0] REG_EVT_STAMP = 8'h60;
	localparam logic [7:0] REG_UPDN = 8'h70;
	localparam logic [7:0] REG_ECHO = 8'h78;
	localparam logic [7:0] REG_END = 8'h80;
	localparam logic [7:0] CH_SPAN = 8'h10;
	localparam logic [7:0] PORT_SPAN = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SNSR_MODE_VOLT = 2'h0,
		SNSR_MODE_COUNT = 2'h1,
		SNSR_MODE_EVENT = 2'h2
	} snsr_mode_t;
	typedef enum logic [1:0] {
		SNSR_PORT_GPIO = 2'h0,
		SNSR_PORT_UPDN = 2'h1,
		SNSR_PORT_RANGE = 2'h2
	} snsr_port_t;
	typedef enum logic [2:0] {
		SNSR_RNG_IDLE = 3'h1,
		SNSR_RNG_TRIG = 3'h2,
		SNSR_RNG_WAIT = 3'h4
	} snsr_rng_t;
endpackage

//--- snsr_chan_if.sv
// carrier between the top and one analog threshold channel
`timescale 1ns/1ps
`default_nettype none
interface snsr_chan_if;
	logic tick;
	logic [snsr_pkg::ADC_W-1:0] sample;
	logic [snsr_pkg::ADC_W-1:0] threshold;
	snsr_pkg::snsr_mode_t mode;
	logic clear;
	logic [snsr_pkg::CNT_W-1:0] tstamp;
	logic [snsr_pkg::CNT_W-1:0] count;
	logic [snsr_pkg::CNT_W-1:0] stamp;
	logic evt;
	modport ctrl (output tick, sample, threshold, mode, clear, tstamp, input count, stamp, evt);
	modport chan (input tick, sample, threshold, mode, clear, tstamp, output count, stamp, evt);
endinterface
`default_nettype wire

//--- snsr_thr_chan.sv
// one analog channel: threshold compare, edge count and event time stamp
`timescale 1ns/1ps
`default_nettype none
module snsr_thr_chan (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	snsr_chan_if.chan c
);
	localparam int W = snsr_pkg::CNT_W;
	logic above_ff;
	logic armed_ff;
	logic active;
	logic above;
	logic rise;
	logic [W-1:0] count_ff;
	logic [W-1:0] stamp_ff;
	logic evt_ff;

	always_comb begin
		active = (c.mode == snsr_pkg::SNSR_MODE_COUNT) || (c.mode == snsr_pkg::SNSR_MODE_EVENT);
		above = c.sample > c.threshold;
		rise = c.tick && active && armed_ff && above && !above_ff;
	end

	// first sample after enabling only primes the history: a level already high is not counted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			above_ff <= 1'b0;
			armed_ff <= 1'b0;
		end else if (clk_en && c.tick) begin
			above_ff <= above;
			armed_ff <= active;
		end
	end

	// a clear in the same cycle as an edge keeps that edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_ff <= '0;
		end else if (clk_en) begin
			if (c.clear) begin
				count_ff <= W'(rise);
			end else if (rise) begin
				count_ff <= count_ff + W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stamp_ff <= '0;
			evt_ff <= 1'b0;
		end else if (clk_en) begin
			evt_ff <= rise;
			if (rise && c.mode == snsr_pkg::SNSR_MODE_EVENT) begin
				stamp_ff <= c.tstamp;
			end
		end
	end

	assign c.count = count_ff;
	assign c.stamp = stamp_ff;
	assign c.evt = evt_ff;
endmodule
`default_nettype wire

//--- snsr_top.sv
// sensor input front end: axi4-lite registers, analog threshold channels, digital ports
`timescale 1ns/1ps
`default_nettype none
// Operation
// - counter and event channels sample every 250 us and compare with threshold.
// - channel counter keeps up with 2000 symmetrical pulses per second.
// - event mode keeps a 0.5 ms time stamp per event, readable by software.
// - each analog channel selects voltage, counter or event operation.
// - per-channel range select, wide bipolar or low 0-5 V, low after reset.
// - each digital port has four lines, each set as input or output.
// - a digital port can run as up/down counter for direction sensing sensors.
// - ranging drives a trigger out and times the delay until the echo pulse returns.
module snsr_top #(
	parameter int TICK_CYC = snsr_pkg::TICK_CYC,
	parameter int STAMP_CYC = snsr_pkg::STAMP_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [47:0] adc_wide_data,
	input wire logic [47:0] adc_low_data,
	output logic [3:0] range_wide,
	input wire logic [7:0] dio_in,
	output logic [7:0] dio_out,
	output logic [7:0] dio_oe,
	output logic irq
);
	localparam int NCH = snsr_pkg::NCH;
	localparam int NP = snsr_pkg::NPORT;
	localparam int AW = snsr_pkg::ADC_W;
	localparam int LN = snsr_pkg::LINES;

	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, irq_ff;
	logic aw_got_ff, w_got_ff;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic wr_do, nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid, aw_hs, w_hs, ar_hs;
	logic [31:0] wnew, wbits;
	logic [15:0] tick_cnt_ff, stamp_div_ff, tstamp_ff;
	logic [7:0] us_div_ff;
	logic tick_ff, us_ff;
	snsr_pkg::snsr_mode_t chan_mode_ff [NCH];
	logic [3:0] range_wide_ff;
	logic [AW-1:0] thresh_ff [NCH];
	snsr_pkg::snsr_port_t port_mode_ff [NP];
	logic [7:0] dio_dir_ff, dio_wr_ff, dio_out_ff, dio_oe_ff, din_prev_ff;
	logic [7:0] nxt_dio_out, nxt_dio_oe;
	logic [snsr_pkg::IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
	logic [15:0] ch_count [NCH];
	logic [15:0] ch_stamp [NCH];
	logic [NCH-1:0] ch_evt, cnt_clr;
	logic [15:0] updn_ff [NP];
	logic [15:0] updn_step [NP];
	logic [15:0] echo_ff [NP];
	logic [15:0] rng_tm_ff [NP];
	snsr_pkg::snsr_rng_t rng_st_ff [NP];
	logic [NP-1:0] updn_clr, rng_go, rng_done, echo_rise;

	function automatic logic blk_hit(input logic [7:0] a, input logic [7:0] base,
		input logic [7:0] len);
		blk_hit = (a >= base) && (a < base + len);
	endfunction

	function automatic logic reg_known(input logic [7:0] a);
		reg_known = (a[1:0] == 2'h0) &&
			((a <= snsr_pkg::REG_TIMESTAMP) || blk_hit(a, snsr_pkg::REG_THRESH,
			snsr_pkg::REG_END - snsr_pkg::REG_THRESH));
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (d & m);
	endfunction

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		if (blk_hit(a, snsr_pkg::REG_THRESH, snsr_pkg::CH_SPAN)) begin
			v = 32'(thresh_ff[a[3:2]]);
		end else if (blk_hit(a, snsr_pkg::REG_COUNT, snsr_pkg::CH_SPAN)) begin
			v = 32'(ch_count[a[3:2]]);
		end else if (blk_hit(a, snsr_pkg::REG_EVT_STAMP, snsr_pkg::CH_SPAN)) begin
			v = 32'(ch_stamp[a[3:2]]);
		end else if (blk_hit(a, snsr_pkg::REG_UPDN, snsr_pkg::PORT_SPAN)) begin
			v = 32'(updn_ff[a[2]]);
		end else if (blk_hit(a, snsr_pkg::REG_ECHO, snsr_pkg::PORT_SPAN)) begin
			v = 32'(echo_ff[a[2]]);
		end else begin
			case (a)
				snsr_pkg::REG_CHAN_MODE: begin
					for (int i = 0; i < NCH; i++) begin
						v[snsr_pkg::MODE_W*i +: snsr_pkg::MODE_W] = chan_mode_ff[i];
						v[snsr_pkg::CM_RANGE_LSB + i] = range_wide_ff[i];
					end
				end
				snsr_pkg::REG_PORT_MODE: begin
					for (int p = 0; p < NP; p++) begin
						v[snsr_pkg::PM_W*p +: snsr_pkg::PM_W] = port_mode_ff[p];
					end
				end
				snsr_pkg::REG_DIO_DIR: v = 32'(dio_dir_ff);
				snsr_pkg::REG_DIO_OUT: v = 32'(dio_wr_ff);
				snsr_pkg::REG_DIO_IN: v = 32'(dio_in);
				snsr_pkg::REG_IRQ_STAT: v = 32'(irq_stat_ff);
				snsr_pkg::REG_IRQ_MASK: v = 32'(irq_mask_ff);
				snsr_pkg::REG_TIMESTAMP: v = 32'(tstamp_ff);
				default: v = 32'h0;
			endcase
		end
		reg_read = v;
	endfunction

	// bus handshake: address and data are caught independently, write runs once both are held
	always_comb begin
		aw_hs = s_axi_awvalid && awready_ff;
		w_hs = s_axi_wvalid && wready_ff;
		ar_hs = s_axi_arvalid && arready_ff;
		wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
		nxt_aw_got = !wr_do && (aw_got_ff || aw_hs);
		nxt_w_got = !wr_do && (w_got_ff || w_hs);
		nxt_bvalid = wr_do || (bvalid_ff && !s_axi_bready);
		nxt_rvalid = ar_hs || (rvalid_ff && !s_axi_rready);
		wnew = merge(reg_read(wa), wd, ws);
		wbits = merge(32'h0, wd, ws);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= snsr_pkg::RESP_OKAY;
			wa <= 8'h00;
			wd <= 32'h0;
			ws <= 4'h0;
		end else if (clk_en) begin
			awready_ff <= !nxt_aw_got && !nxt_bvalid;
			wready_ff <= !nxt_w_got && !nxt_bvalid;
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			bvalid_ff <= nxt_bvalid;
			if (aw_hs) begin
				wa <= s_axi_awaddr;
			end
			if (w_hs) begin
				wd <= s_axi_wdata;
				ws <= s_axi_wstrb;
			end
			if (wr_do) begin
				bresp_ff <= reg_known(wa) ? snsr_pkg::RESP_OKAY : snsr_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= snsr_pkg::RESP_OKAY;
		end else if (clk_en) begin
			arready_ff <= !nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (ar_hs) begin
				rdata_ff <= reg_known(s_axi_araddr) ? reg_read(s_axi_araddr) : 32'h0;
				rresp_ff <= reg_known(s_axi_araddr) ? snsr_pkg::RESP_OKAY : snsr_pkg::RESP_SLVERR;
			end
		end
	end

	// timebase: sample tick, half-millisecond stamp and microsecond strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_ff <= 16'h0000;
			tick_ff <= 1'b0;
			stamp_div_ff <= 16'h0000;
			tstamp_ff <= 16'h0000;
			us_div_ff <= 8'h00;
			us_ff <= 1'b0;
		end else if (clk_en) begin
			tick_ff <= tick_cnt_ff == 16'(TICK_CYC - 1);
			tick_cnt_ff <= (tick_cnt_ff == 16'(TICK_CYC - 1)) ? 16'h0000 : tick_cnt_ff + 16'h0001;
			if (stamp_div_ff == 16'(STAMP_CYC - 1)) begin
				stamp_div_ff <= 16'h0000;
				tstamp_ff <= tstamp_ff + 16'h0001;
			end else begin
				stamp_div_ff <= stamp_div_ff + 16'h0001;
			end
			us_ff <= us_div_ff == 8'(snsr_pkg::US_CYC - 1);
			us_div_ff <= (us_div_ff == 8'(snsr_pkg::US_CYC - 1)) ? 8'h00 : us_div_ff + 8'h01;
		end
	end

	// configuration written by software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NCH; i++) begin
				chan_mode_ff[i] <= snsr_pkg::SNSR_MODE_VOLT;
				thresh_ff[i] <= snsr_pkg::THRESH_RST;
			end
			for (int p = 0; p < NP; p++) begin
				port_mode_ff[p] <= snsr_pkg::SNSR_PORT_GPIO;
			end
			range_wide_ff <= 4'h0;
			dio_dir_ff <= 8'h00;
			dio_wr_ff <= 8'h00;
			irq_mask_ff <= '0;
		end else if (clk_en && wr_do) begin
			if (wa == snsr_pkg::REG_CHAN_MODE) begin
				for (int i = 0; i < NCH; i++) begin
					chan_mode_ff[i] <= snsr_pkg::snsr_mode_t'(wnew[snsr_pkg::MODE_W*i +: snsr_pkg::MODE_W]);
					range_wide_ff[i] <= wnew[snsr_pkg::CM_RANGE_LSB + i];
				end
			end
			if (wa == snsr_pkg::REG_PORT_MODE) begin
				for (int p = 0; p < NP; p++) begin
					port_mode_ff[p] <= snsr_pkg::snsr_port_t'(wnew[snsr_pkg::PM_W*p +: snsr_pkg::PM_W]);
				end
			end
			if (blk_hit(wa, snsr_pkg::REG_THRESH, snsr_pkg::CH_SPAN)) begin
				thresh_ff[wa[3:2]] <= wnew[AW-1:0];
			end
			if (wa == snsr_pkg::REG_DIO_DIR) begin
				dio_dir_ff <= wnew[7:0];
			end
			if (wa == snsr_pkg::REG_DIO_OUT) begin
				dio_wr_ff <= wnew[7:0];
			end
			if (wa == snsr_pkg::REG_IRQ_MASK) begin
				irq_mask_ff <= wnew[snsr_pkg::IRQ_W-1:0];
			end
		end
	end

	// analog channels; the converter runs freely and the tick picks the sample
	snsr_chan_if ch_if [NCH] ();
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		assign cnt_clr[g] = wr_do && blk_hit(wa, snsr_pkg::REG_COUNT, snsr_pkg::CH_SPAN) &&
			(wa[3:2] == 2'(g));
		assign ch_if[g].tick = tick_ff;
		assign ch_if[g].sample = range_wide_ff[g] ? adc_wide_data[AW*g +: AW] :
			adc_low_data[AW*g +: AW];
		assign ch_if[g].threshold = thresh_ff[g];
		assign ch_if[g].mode = chan_mode_ff[g];
		assign ch_if[g].clear = cnt_clr[g];
		assign ch_if[g].tstamp = tstamp_ff;
		assign ch_count[g] = ch_if[g].count;
		assign ch_stamp[g] = ch_if[g].stamp;
		assign ch_evt[g] = ch_if[g].evt;
		snsr_thr_chan u_chan (
			.aclk(aclk),
			.aresetn(aresetn),
			.clk_en(clk_en),
			.c(ch_if[g])
		);
	end

	// digital port pin control and per-port event decode
	always_comb begin
		nxt_dio_oe = dio_dir_ff;
		nxt_dio_out = dio_wr_ff;
		for (int p = 0; p < NP; p++) begin
			echo_rise[p] = dio_in[LN*p + snsr_pkg::PIN_ECHO] && !din_prev_ff[LN*p + snsr_pkg::PIN_ECHO];
			updn_clr[p] = wr_do && blk_hit(wa, snsr_pkg::REG_UPDN, snsr_pkg::PORT_SPAN) &&
				(wa[2] == 1'(p));
			rng_go[p] = wr_do && (wa == snsr_pkg::REG_RANGE_GO) && wbits[p] &&
				(port_mode_ff[p] == snsr_pkg::SNSR_PORT_RANGE);
			rng_done[p] = (rng_st_ff[p] == snsr_pkg::SNSR_RNG_WAIT) &&
				(port_mode_ff[p] == snsr_pkg::SNSR_PORT_RANGE) &&
				(echo_rise[p] || rng_tm_ff[p] == 16'hffff);
			updn_step[p] = 16'h0000;
			if (port_mode_ff[p] == snsr_pkg::SNSR_PORT_UPDN) begin
				nxt_dio_oe[LN*p + snsr_pkg::PIN_CLK] = 1'b0;
				nxt_dio_oe[LN*p + snsr_pkg::PIN_DIR] = 1'b0;
				if (dio_in[LN*p + snsr_pkg::PIN_CLK] && !din_prev_ff[LN*p + snsr_pkg::PIN_CLK]) begin
					updn_step[p] = dio_in[LN*p + snsr_pkg::PIN_DIR] ? 16'h0001 : 16'hffff;
				end
			end else if (port_mode_ff[p] == snsr_pkg::SNSR_PORT_RANGE) begin
				nxt_dio_oe[LN*p + snsr_pkg::PIN_ECHO] = 1'b0;
				nxt_dio_oe[LN*p + snsr_pkg::PIN_TRIG] = 1'b1;
				nxt_dio_out[LN*p + snsr_pkg::PIN_TRIG] = rng_st_ff[p] == snsr_pkg::SNSR_RNG_TRIG;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dio_out_ff <= 8'h00;
			dio_oe_ff <= 8'h00;
			din_prev_ff <= 8'h00;
		end else if (clk_en) begin
			dio_out_ff <= nxt_dio_out;
			dio_oe_ff <= nxt_dio_oe;
			din_prev_ff <= dio_in;
		end
	end

	// a clear that meets a count edge keeps the edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < NP; p++) begin
				updn_ff[p] <= 16'h0000;
			end
		end else if (clk_en) begin
			for (int p = 0; p < NP; p++) begin
				updn_ff[p] <= (updn_clr[p] ? 16'h0000 : updn_ff[p]) + updn_step[p];
			end
		end
	end

	// ranging: trigger pulse, then echo delay in microseconds, saturating when nothing returns
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < NP; p++) begin
				rng_st_ff[p] <= snsr_pkg::SNSR_RNG_IDLE;
				rng_tm_ff[p] <= 16'h0000;
				echo_ff[p] <= 16'h0000;
			end
		end else if (clk_en) begin
			for (int p = 0; p < NP; p++) begin
				case (rng_st_ff[p])
					snsr_pkg::SNSR_RNG_IDLE: begin
						if (rng_go[p]) begin
							rng_st_ff[p] <= snsr_pkg::SNSR_RNG_TRIG;
							rng_tm_ff[p] <= 16'h0000;
						end
					end
					snsr_pkg::SNSR_RNG_TRIG: begin
						rng_tm_ff[p] <= rng_tm_ff[p] + 16'h0001;
						if (rng_tm_ff[p] == 16'(snsr_pkg::TRIG_CYC - 1)) begin
							rng_st_ff[p] <= snsr_pkg::SNSR_RNG_WAIT;
							rng_tm_ff[p] <= 16'h0000;
						end
					end
					snsr_pkg::SNSR_RNG_WAIT: begin
						if (us_ff && rng_tm_ff[p] != 16'hffff) begin
							rng_tm_ff[p] <= rng_tm_ff[p] + 16'h0001;
						end
						if (rng_done[p]) begin
							echo_ff[p] <= rng_tm_ff[p];
							rng_st_ff[p] <= snsr_pkg::SNSR_RNG_IDLE;
						end
					end
					default: rng_st_ff[p] <= snsr_pkg::SNSR_RNG_IDLE;
				endcase
				if (port_mode_ff[p] != snsr_pkg::SNSR_PORT_RANGE) begin
					rng_st_ff[p] <= snsr_pkg::SNSR_RNG_IDLE;
				end
			end
		end
	end

	// sticky status: a new event beats a write-one clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= '0;
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			irq_stat_ff <= (irq_stat_ff & ~((wr_do && wa == snsr_pkg::REG_IRQ_STAT) ?
				wbits[snsr_pkg::IRQ_W-1:0] : '0)) | {rng_done, ch_evt};
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign range_wide = range_wide_ff;
	assign dio_out = dio_out_ff;
	assign dio_oe = dio_oe_ff;
	assign irq = irq_ff;
endmodule
`default_nettype wire

//--- snsr_top_asserts.sv
// concurrent checks on the sensor front end top-level ports
`timescale 1ns/1ps
`default_nettype none
module snsr_top_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [3:0] range_wide,
	input wire logic [7:0] dio_out,
	input wire logic irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic wr_hs;
	logic [9:0] trig_ff;
	logic [3:0] rng_ff;
	assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// high cycles of the port 0 trigger, judged when it falls
	always_ff @(posedge aclk) begin
		if (!aresetn || !dio_out[1]) begin
			trig_ff <= 10'h000;
		end else begin
			trig_ff <= trig_ff + 10'h001;
		end
	end
	always_ff @(posedge aclk) begin
		if (wr_hs) begin
			rng_ff <= s_axi_wdata[11:8];
		end
	end
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data not held");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_write_lat: assert property (wr_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response timing wrong");
	a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
		&& !irq && range_wide == 4'h0)
		else $error("outputs not idle after reset");
	a_range_sel: assert property (wr_hs && s_axi_awaddr == snsr_pkg::REG_CHAN_MODE
		&& s_axi_wstrb[1] |-> ##3 range_wide == rng_ff)
		else $error("range select does not follow write");
	a_trig_width: assert property ($fell(dio_out[1]) |-> trig_ff == 10'(snsr_pkg::TRIG_CYC))
		else $error("trigger pulse width wrong");
	c_write: cover property (wr_hs);
	c_trig: cover property ($fell(dio_out[1]));
	c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

//--- snsr_sensor_model.sv
// behavioural sensors: threshold signals, ranging echo, digital lines
`timescale 1ns/1ps
`default_nettype none
module snsr_sensor_model (
	input wire logic aclk,
	input wire logic [3:0] chan_hi,
	input wire logic [15:0] echo_dly,
	input wire logic [7:0] dio_ext,
	input wire logic [7:0] dio_out,
	input wire logic [7:0] dio_oe,
	output logic [47:0] adc_wide_data,
	output logic [47:0] adc_low_data,
	output logic [7:0] dio_in
);
	logic trig_q = 1'b0;
	int cnt = 0;
	logic echo;
	// wide pin sits low, so a channel on the wide range never crosses the threshold
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			adc_low_data[12*i +: 12] = chan_hi[i] ? 12'h900 : 12'h100;
			adc_wide_data[12*i +: 12] = 12'h100;
		end
	end
	// echo returns echo_dly cycles after the trigger ends, as a logic-level pulse
	always @(posedge aclk) begin
		trig_q <= dio_oe[1] && dio_out[1];
		if (trig_q && !(dio_oe[1] && dio_out[1])) begin
			cnt <= 1;
		end else if (cnt != 0) begin
			cnt <= (cnt > echo_dly + 100) ? 0 : cnt + 1;
		end
	end
	assign echo = cnt > echo_dly;
	assign dio_in = (dio_oe & dio_out) | (~dio_oe & {dio_ext[7:1], dio_ext[0] | echo});
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the sensor front end
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int TICK = 20;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, dio_ext = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, rd_q;
	logic [3:0] s_axi_wstrb = 4'hf, chan_hi = 4'h0;
	// the echo delay of 148 cycles plus two cycles of latency is a whole number of microsecond strobes, so the result does not depend on the strobe phase
	logic [15:0] echo_dly = 16'h0094, ts_q;
	logic [1:0] resp_q;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [47:0] adc_wide_data, adc_low_data;
	wire [7:0] dio_in, dio_out, dio_oe;
	wire [3:0] range_wide;
	int err_total = 0, cmp_count = 0, cyc = 0, rel = 0;
	always #10 aclk = ~aclk;
	snsr_top #(.TICK_CYC(TICK), .STAMP_CYC(40)) snsr_top_i (.aclk, .aresetn, .clk_en(1'b1),
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .adc_wide_data, .adc_low_data, .range_wide, .dio_in,
		.dio_out, .dio_oe, .irq);
	snsr_sensor_model snsr_sensor_model_i (.aclk, .chan_hi, .echo_dly, .dio_ext, .dio_out,
		.dio_oe, .adc_wide_data, .adc_low_data, .dio_in);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
		end while (!s_axi_bvalid);
		// the answer waits one cycle so the response hold checks see a stall
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		resp_q = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		rd_q = s_axi_rdata;
		resp_q = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// levels change mid-period so each one is seen by exactly the intended ticks
	task automatic pulse(input int n);
		chan_hi <= 4'hf;
		repeat (n * TICK) @(posedge aclk);
		chan_hi <= 4'h0;
		repeat (n * TICK) @(posedge aclk);
	endtask
	task automatic dpulse();
		dio_ext[4] <= 1'b1;
		repeat (4) @(posedge aclk);
		dio_ext[4] <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	task automatic t_reset();
		chk(range_wide, 4'h0);
		rd(snsr_pkg::REG_CHAN_MODE);
		chk(rd_q, 32'h0);
		rd(snsr_pkg::REG_THRESH);
		chk(rd_q[11:0], snsr_pkg::THRESH_RST);
		rd(8'hfc);
		chk(resp_q, snsr_pkg::RESP_SLVERR);
		wr(8'hfc, 32'h1);
		chk(resp_q, snsr_pkg::RESP_SLVERR);
	endtask
	task automatic t_count();
		logic [15:0] exp_c [4];
		exp_c = '{16'h0005, 16'h0005, 16'h0000, 16'h0000};
		// ch0 counter, ch1 event, ch2 voltage, ch3 counter on the wide input
		wr(snsr_pkg::REG_CHAN_MODE, 32'h849);
		repeat (3) @(posedge aclk);
		chk(range_wide, 4'h8);
		do begin
			@(posedge aclk);
		end while ((cyc - rel) % TICK != TICK / 2);
		repeat (2 * TICK) @(posedge aclk);
		repeat (4) pulse(1);
		pulse(3);
		repeat (2 * TICK) @(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			rd(snsr_pkg::REG_COUNT + 8'(i * 4));
			chk(rd_q[15:0], exp_c[i]);
		end
		rd(snsr_pkg::REG_IRQ_STAT);
		chk(rd_q[5:0], 6'h03);
		chk(irq, 1'b0);
		wr(snsr_pkg::REG_IRQ_MASK, 32'h1);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b1);
		wr(snsr_pkg::REG_IRQ_STAT, 32'h1);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		rd(snsr_pkg::REG_EVT_STAMP);
		chk(rd_q[15:0], 16'h0000);
		rd(snsr_pkg::REG_TIMESTAMP);
		ts_q = rd_q[15:0];
		rd(snsr_pkg::REG_EVT_STAMP + 8'h04);
		chk({31'h0, ts_q - rd_q[15:0] <= 16'h0006 && rd_q[15:0] != 16'h0000}, 32'h1);
		repeat (400) @(posedge aclk);
		rd(snsr_pkg::REG_TIMESTAMP);
		ts_q = rd_q[15:0] - ts_q;
		chk({31'h0, ts_q == 16'h000a || ts_q == 16'h000b}, 32'h1);
	endtask
	task automatic t_gpio();
		wr(snsr_pkg::REG_DIO_DIR, 32'h50);
		wr(snsr_pkg::REG_DIO_OUT, 32'hf0);
		dio_ext <= 8'ha0;
		repeat (4) @(posedge aclk);
		chk(dio_oe, 8'h50);
		chk(dio_out & 8'h50, 8'h50);
		rd(snsr_pkg::REG_DIO_IN);
		chk(rd_q[7:0], 8'hf0);
	endtask
	task automatic t_updn();
		wr(snsr_pkg::REG_PORT_MODE, 32'h4);
		repeat (2) @(posedge aclk);
		chk(dio_oe, 8'h40);
		repeat (3) dpulse();
		dio_ext[5] <= 1'b0;
		repeat (5) dpulse();
		rd(snsr_pkg::REG_UPDN + snsr_pkg::PORT_SPAN / 2);
		chk(rd_q[15:0], 16'hfffe);
	endtask
	task automatic t_range();
		int n;
		n = 0;
		wr(snsr_pkg::REG_PORT_MODE, 32'h6);
		wr(snsr_pkg::REG_RANGE_GO, 32'h1);
		repeat (5) @(posedge aclk);
		chk(dio_oe[1] & dio_out[1], 1'b1);
		do begin
			rd(snsr_pkg::REG_IRQ_STAT);
			n++;
		end while (rd_q[4] !== 1'b1 && n < 300);
		chk(rd_q[4], 1'b1);
		rd(snsr_pkg::REG_ECHO);
		chk(rd_q[15:0], 16'h0003);
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// the whole run needs well under ten thousand cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rel = cyc;
		t_reset();
		t_count();
		t_gpio();
		t_updn();
		t_range();
		tally_and_finish();
	end
endmodule
bind snsr_top snsr_top_asserts snsr_top_asserts_i (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .range_wide, .dio_out, .irq);
`default_nettype wire
